// [wdtg_top.sv]
// wdtg_top.sv - two-stage watchdog: interrupt on first time-out, reset on second
`timescale 1ns/100ps
module wdtg_top #(
  parameter logic [wdtg_pkg::DIV_W-1:0] CLK_DIV = wdtg_pkg::DIV_DFLT
) (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_cfg_wr,
  input  wire logic [wdtg_pkg::CNT_W-1:0] i_cfg_load,
  input  wire logic                      i_cfg_int_en,
  input  wire logic                      i_cfg_rst_en,
  input  wire logic                      i_cfg_int_mask,
  input  wire logic                      i_cfg_stall_en,
  input  wire logic                      i_cfg_clk_en,
  input  wire logic                      i_lock_wr,
  input  wire logic                      i_unlock_wr,
  input  wire logic                      i_int_clear,
  input  wire logic                      i_cpu_halt,
  output logic [wdtg_pkg::CNT_W-1:0]     o_count,
  output logic                           o_int_status,
  output logic                           o_int,
  output logic                           o_sys_rst,
  output logic                           o_locked
);
  // ==========================================================================
  // configuration registers
  logic [wdtg_pkg::CNT_W-1:0] load_value;
  logic                       int_en;
  logic                       rst_en;
  logic                       int_mask;
  logic                       stall_en;
  logic                       clk_en;
  logic                       locked;
  wire                        cfg_take = i_cfg_wr & ~locked;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      load_value <= wdtg_pkg::LOAD_RST;
      int_en     <= 1'b0;
      rst_en     <= 1'b0;
      int_mask   <= 1'b0;
      stall_en   <= 1'b0;
      clk_en     <= 1'b0;
    end else if (cfg_take) begin
      load_value <= i_cfg_load;
      int_en     <= i_cfg_int_en;
      rst_en     <= i_cfg_rst_en;
      int_mask   <= i_cfg_int_mask;
      stall_en   <= i_cfg_stall_en;
      clk_en     <= i_cfg_clk_en;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      locked <= 1'b0;
    end else if (i_unlock_wr) begin
      locked <= 1'b0;
    end else if (i_lock_wr) begin
      locked <= 1'b1;
    end
  end

  // ==========================================================================
  // watchdog clock: divider enable, gated by software enable and debug stall
  logic [wdtg_pkg::DIV_W-1:0] div_cnt;
  wire                        stalled  = stall_en & i_cpu_halt;
  wire                        run      = clk_en & ~stalled;
  wire                        div_last = (div_cnt == CLK_DIV - wdtg_pkg::DIV_ONE);
  wire                        tick     = run & div_last;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt <= wdtg_pkg::DIV_ZERO;
    end else if (run) begin
      div_cnt <= div_last ? wdtg_pkg::DIV_ZERO : div_cnt + wdtg_pkg::DIV_ONE;
    end
  end

  // ==========================================================================
  // counter
  wdtg_pkg::wdtg_state_t state;
  wdtg_pkg::wdtg_state_t next_state;
  wdtg_cnt_if cnt_bus ();
  wire        clear_take = i_int_clear & (state != wdtg_pkg::ST_RESET);

  assign cnt_bus.tick       = tick;
  assign cnt_bus.load       = cfg_take | clear_take;
  assign cnt_bus.load_value = cfg_take ? i_cfg_load : load_value;

  wdtg_counter u_counter (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .bus       (cnt_bus.cnt)
  );

  // ==========================================================================
  // time-out stages
  wire                   timeout = cnt_bus.timeout;

  always_comb begin
    next_state = state;
    unique case (state)
      wdtg_pkg::ST_RUN: begin
        if (timeout) begin
          next_state = wdtg_pkg::ST_FIRST;
        end
      end
      wdtg_pkg::ST_FIRST: begin
        if (timeout & rst_en) begin
          next_state = wdtg_pkg::ST_RESET;
        end else if (i_int_clear & ~timeout) begin
          next_state = wdtg_pkg::ST_RUN;
        end
      end
      wdtg_pkg::ST_RESET: begin
        next_state = wdtg_pkg::ST_RESET;
      end
      default: begin
        next_state = wdtg_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= wdtg_pkg::ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // registered outputs
  wire next_first = (next_state == wdtg_pkg::ST_FIRST);
  wire next_reset = (next_state == wdtg_pkg::ST_RESET);

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_int_status <= 1'b0;
      o_int        <= 1'b0;
      o_sys_rst    <= 1'b0;
      o_locked     <= 1'b0;
      o_count      <= wdtg_pkg::LOAD_RST;
    end else begin
      o_int_status <= next_first & int_en;
      o_int        <= next_first & int_en & ~int_mask;
      o_sys_rst    <= next_reset;
      o_locked     <= i_unlock_wr ? 1'b0 : (i_lock_wr | locked);
      o_count      <= cnt_bus.count;
    end
  end

  // ==========================================================================
  // assertions
  property p_first_int;
    @(posedge i_sys_clk) disable iff (i_rst)
    timeout && state == wdtg_pkg::ST_RUN && int_en && !int_mask |=> o_int;
  endproperty
  a_first_int: assert property (p_first_int) else $error("no interrupt on first time-out");

  property p_second_rst;
    @(posedge i_sys_clk) disable iff (i_rst)
    timeout && state == wdtg_pkg::ST_FIRST && rst_en |=> o_sys_rst ##1 o_sys_rst;
  endproperty
  a_second_rst: assert property (p_second_rst) else $error("second time-out gave no reset");

  property p_lock;
    @(posedge i_sys_clk) disable iff (i_rst)
    locked && i_cfg_wr |=> $stable(load_value) && $stable(rst_en) && $stable(clk_en)
      && $stable(int_en) && $stable(int_mask) && $stable(stall_en);
  endproperty
  a_lock: assert property (p_lock) else $error("locked configuration changed");

  property p_rst_en;
    @(posedge i_sys_clk) disable iff (i_rst)
    $rose(o_sys_rst) |-> $past(rst_en) && $past(state) == wdtg_pkg::ST_FIRST;
  endproperty
  a_rst_en: assert property (p_rst_en) else $error("reset raised while disabled");

  property p_mask;
    @(posedge i_sys_clk) disable iff (i_rst)
    int_mask && !cfg_take |=> !o_int;
  endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt reached output");

  property p_clk_en;
    @(posedge i_sys_clk) disable iff (i_rst)
    !clk_en |-> !tick ##1 (clk_en || $stable(div_cnt));
  endproperty
  a_clk_en: assert property (p_clk_en) else $error("counting while clock disabled");

  property p_stall;
    @(posedge i_sys_clk) disable iff (i_rst)
    stall_en && i_cpu_halt && !cnt_bus.load |=> $stable(cnt_bus.count);
  endproperty
  a_stall: assert property (p_stall) else $error("counter moved during debug halt");

  property p_period;
    @(posedge i_sys_clk) disable iff (i_rst)
    timeout && !cnt_bus.load |=> cnt_bus.count == $past(load_value);
  endproperty
  a_period: assert property (p_period) else $error("no full reload after time-out");
endmodule : wdtg_top

// [wdtg_pkg.sv]
// wdtg_pkg.sv - constants and types shared by the two-stage watchdog
package wdtg_pkg;
  localparam int              CNT_W     = 32;
  localparam int              DIV_W     = 8;
  localparam logic [CNT_W-1:0] LOAD_RST = 32'hFFFFFFFF;
  localparam logic [CNT_W-1:0] CNT_ONE  = 32'h00000001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h00000000;
  localparam logic [DIV_W-1:0] DIV_ONE  = 8'h01;
  localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;
  localparam logic [DIV_W-1:0] DIV_DFLT = 8'h01;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_FIRST = 2'b01,
    ST_RESET = 2'b10
  } wdtg_state_t;
endpackage : wdtg_pkg

// [wdtg_cnt_if.sv]
// wdtg_cnt_if.sv - link between watchdog control and its down counter
`timescale 1ns/100ps
interface wdtg_cnt_if;
  logic                      tick;
  logic                      load;
  logic [wdtg_pkg::CNT_W-1:0] load_value;
  logic [wdtg_pkg::CNT_W-1:0] count;
  logic                      timeout;

  modport ctl (output tick, output load, output load_value, input count, input timeout);
  modport cnt (input tick, input load, input load_value, output count, output timeout);
endinterface : wdtg_cnt_if

// [wdtg_counter.sv]
// wdtg_counter.sv - 32-bit watchdog down counter with reload on zero
`timescale 1ns/100ps
module wdtg_counter (
  input  wire logic i_sys_clk,
  input  wire logic i_rst,
  wdtg_cnt_if.cnt   bus
);
  logic [wdtg_pkg::CNT_W-1:0] count;
  wire                        at_zero = (count == wdtg_pkg::CNT_ZERO);

  // timeout is not masked by a same-cycle load so the event is never lost
  assign bus.timeout = bus.tick & at_zero;
  assign bus.count   = count;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      count <= wdtg_pkg::LOAD_RST;
    end else if (bus.load | (bus.tick & at_zero)) begin
      count <= bus.load_value;
    end else if (bus.tick) begin
      count <= count - wdtg_pkg::CNT_ONE;
    end
  end

  property p_cnt_dec;
    @(posedge i_sys_clk) disable iff (i_rst)
    bus.tick && !bus.load && !at_zero |=> count == $past(count) - wdtg_pkg::CNT_ONE;
  endproperty
  a_cnt_dec: assert property (p_cnt_dec) else $error("counter did not decrement");

  property p_reload;
    @(posedge i_sys_clk) disable iff (i_rst)
    bus.tick && at_zero |=> count == $past(bus.load_value);
  endproperty
  a_reload: assert property (p_reload) else $error("counter did not reload at zero");
endmodule : wdtg_counter

// [wdtg_top_test.sv]
// wdtg_top_test.sv - self-checking bench for the two-stage watchdog
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module wdtg_top_test;
  logic        clk = 0, rst = 1, wr = 0, ie = 0, re = 0, mk = 0, se = 0, ce = 0;
  logic        lk = 0, ulk = 0, clr = 0, halt = 0;
  logic [31:0] ld = 32'h00000000, cnt, c0;
  logic        st, irq, srst, locked;
  int          fails = 0, n_checks = 0, n;

  always #2.5 clk = ~clk;

  wdtg_top #(.CLK_DIV(8'h01)) DUT (
    .i_sys_clk(clk), .i_rst(rst), .i_cfg_wr(wr), .i_cfg_load(ld),
    .i_cfg_int_en(ie), .i_cfg_rst_en(re), .i_cfg_int_mask(mk),
    .i_cfg_stall_en(se), .i_cfg_clk_en(ce), .i_lock_wr(lk),
    .i_unlock_wr(ulk), .i_int_clear(clr), .i_cpu_halt(halt), .o_count(cnt),
    .o_int_status(st), .o_int(irq), .o_sys_rst(srst), .o_locked(locked));

  // ==========================================================
  // helpers
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc

  task automatic do_reset;
    @(posedge clk); rst <= 1'b1;
    cyc(6);
    @(posedge clk); rst <= 1'b0;
    cyc(1);
  endtask : do_reset

  task automatic cfg(input logic [31:0] v, input logic i, r, m, s, c);
    @(posedge clk);
    wr <= 1'b1; ld <= v; ie <= i; re <= r; mk <= m; se <= s; ce <= c;
    @(posedge clk); wr <= 1'b0;
    cyc(3);
  endtask : cfg

  task automatic wait_on(ref logic s);
    n = 0;
    while (s !== 1'b1 && n < 60) begin cyc(1); n++; end
    if (n >= 60) fails++;
  endtask : wait_on

  // ==========================================================
  // scenarios
  task automatic t_load;
    `CHK(cnt, 32'hFFFFFFFF)
    `CHK({st, irq, srst, locked}, 4'h0)
    cfg(32'h00000014, 0, 0, 0, 0, 0);
    cyc(5);
    `CHK(cnt, 32'h00000014)
    cfg(32'h00000014, 0, 0, 0, 0, 1);
    c0 = cnt;
    cyc(5);
    `CHK(cnt, c0 - 32'h00000005)
  endtask : t_load

  task automatic t_stages;
    do_reset;
    cfg(32'h00000008, 1, 1, 0, 0, 1);
    wait_on(irq);
    `CHK(irq, 1'b1)
    `CHK(srst, 1'b0)
    wait_on(srst);
    `CHK(n, 9)
  endtask : t_stages

  task automatic t_mask_clear;
    do_reset;
    cfg(32'h00000006, 1, 1, 1, 0, 1);
    wait_on(st);
    `CHK(st, 1'b1)
    `CHK(irq, 1'b0)
    @(posedge clk); clr <= 1'b1;
    @(posedge clk); clr <= 1'b0;
    cyc(2);
    `CHK(st, 1'b0)
    cyc(3);
    `CHK(srst, 1'b0)
    wait_on(st);
    `CHK(n, 2)
    `CHK(st, 1'b1)
    `CHK(srst, 1'b0)
  endtask : t_mask_clear

  task automatic t_rst_off;
    do_reset;
    cfg(32'h00000002, 1, 0, 0, 0, 1);
    cyc(30);
    `CHK(irq, 1'b1)
    `CHK(srst, 1'b0)
  endtask : t_rst_off

  task automatic t_stall;
    do_reset;
    cfg(32'h00000064, 0, 0, 0, 1, 1);
    @(posedge clk); halt <= 1'b1;
    cyc(3);
    c0 = cnt;
    cyc(5);
    `CHK(cnt, c0)
    @(posedge clk); halt <= 1'b0;
    cyc(3);
    c0 = cnt;
    cyc(4);
    `CHK(cnt, c0 - 32'h00000004)
  endtask : t_stall

  task automatic t_lock;
    do_reset;
    cfg(32'h00000032, 0, 0, 0, 0, 0);
    @(posedge clk); lk <= 1'b1;
    @(posedge clk); lk <= 1'b0;
    cyc(2);
    `CHK(locked, 1'b1)
    cfg(32'h00000009, 0, 0, 0, 0, 1);
    `CHK(cnt, 32'h00000032)
    @(posedge clk); ulk <= 1'b1;
    @(posedge clk); ulk <= 1'b0;
    cyc(2);
    `CHK(locked, 1'b0)
    cfg(32'h00000009, 0, 0, 0, 0, 0);
    `CHK(cnt, 32'h00000009)
  endtask : t_lock

  // ==========================================================
  // verdict
  task automatic final_report;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  initial begin
    #100000;
    fails++;
    final_report;
  end

  initial begin
    cyc(6);
    @(posedge clk); rst <= 1'b0;
    cyc(1);
    t_load;
    t_stages;
    t_mask_clear;
    t_rst_off;
    t_stall;
    t_lock;
    final_report;
  end
endmodule : wdtg_top_test
